// ---- rbhd_top.sv ----
// reset button hold decoder for the hosted operating system
`timescale 1ns/100ps
`include "rbhd_params.svh"
// Function
// R1 - act on presses only while the controller reports power good
// R2 - release after 1 to under 5 s requests a soft restart
// R3 - 5 to under 10 s shows the hard word, then forces hard restart
// R4 - 10 to under 15 s in program position: utilities restart plus controller
// R5 - 10 to under 15 s in run or remote: show mode word only
// R6 - 15 s or more cancels everything and leaves the display as it was
// R7 - while held, display shows the word of the current interval
// R8 - action is decided and launched at release from measured hold
// R9 - soft restart waits about 5 minutes, then a hard restart follows unless the hosted os reports restart done
// R10 - presses never disturb the real-time control engine; here a 10 to under 15 s hold in program position pulses controller_restart
// R11 - hosted os may start only at the working firmware revision or later
// R12 - a shut down hosted os restarts by soft or hard request
// R13 - hosted os restart or failure barely touches real-time control
// R14 - button synchronised, debounced, seconds counted from each press
module rbhd_top
    import rbhd_pkg::*;
#(
    // real rates by default; shortened only where a bench must reach seconds
    parameter int DEBOUNCE_CYC = `RBHD_DEBOUNCE_CYC,
    parameter int SEC_CYC      = `RBHD_SEC_CYC
) (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      rst,
    // controller status
    input  wire logic                      power_good,
    input  wire rbhd_pkg::rbhd_switch_type mode_switch,
    input  wire logic [15:0]               firmware_rev,
    // operator
    input  wire logic                      button_n,
    // hosted os side
    input  wire logic                      hosted_os_restart_done,
    output logic                           hosted_os_run_enable,
    output logic                           hosted_os_soft_restart,
    output logic                           hosted_os_hard_restart,
    output logic                           hosted_os_utilities,
    output logic                           controller_restart,
    // display
    output logic [31:0]                    display_word
);
    import rbhd_pkg::*;

    localparam int SOFT_WAIT_S = `RBHD_SOFT_WAIT_S;

    rbhd_btn_if btn ();

    logic [4:0]        hold_s_r;
    rbhd_interval_type iv;
    logic [8:0]        wait_s_r;
    logic              wait_r;
    logic              soft_r;
    logic              hard_r;
    logic              util_r;
    logic              ctl_r;
    logic              run_en_r;
    logic [31:0]       disp_r;
    logic              act;
    logic              go_soft;
    logic              go_hard;
    logic              go_util;

    // =========================================================
    // button front end
    rbhd_debounce #(
        .DEBOUNCE_CYC (DEBOUNCE_CYC),
        .SEC_CYC      (SEC_CYC)
    ) u_debounce (
        .clk      (clk),
        .rst      (rst),
        .button_n (button_n),
        .btn      (btn)
    );

    // maps elapsed seconds to an interval
    function automatic rbhd_interval_type rbhd_decode(input logic [4:0] s);
        if (s >= 5'(`RBHD_CANCEL_S))        return RBHD_IV_CANCEL;
        else if (s >= 5'(`RBHD_UTIL_MIN_S)) return RBHD_IV_TEN;
        else if (s >= 5'(`RBHD_HARD_MIN_S)) return RBHD_IV_HARD;
        else if (s >= 5'(`RBHD_SOFT_MIN_S)) return RBHD_IV_SOFT;
        else                                return RBHD_IV_SHORT;
    endfunction

    // =========================================================
    // hold timer
    // R14 seconds counted from press, saturating past cancel
    always_ff @(posedge clk) begin
        if (rst || btn.press) begin
            hold_s_r <= 5'h0;
        end else if (btn.held && btn.sec_tick && hold_s_r != 5'h1f) begin
            hold_s_r <= hold_s_r + 5'h1;
        end
    end

    assign iv = rbhd_decode(hold_s_r);
    // R1 presses ignored without power
    assign act = btn.release_p && power_good;
    // R8 decision made at release
    assign go_util = act && iv == RBHD_IV_TEN && mode_switch == RBHD_SW_PROGRAM;
    assign go_hard = act && iv == RBHD_IV_HARD;
    assign go_soft = act && iv == RBHD_IV_SOFT;

    // =========================================================
    // display
    // R7 word follows the live interval while held
    always_ff @(posedge clk) begin
        if (rst) begin
            disp_r <= `RBHD_WORD_BLANK;
        end else if (btn.held && power_good) begin
            unique case (iv)
                RBHD_IV_HARD: disp_r <= `RBHD_WORD_HRDR;
                // R4 R5 utilities or mode word by switch
                RBHD_IV_TEN:  disp_r <= (mode_switch == RBHD_SW_PROGRAM) ?
                                        `RBHD_WORD_UTIL : `RBHD_WORD_MODE;
                // R6 cancel leaves the word alone
                RBHD_IV_CANCEL: disp_r <= disp_r;
                RBHD_IV_SHORT,
                RBHD_IV_SOFT:   disp_r <= `RBHD_WORD_BLANK;
            endcase
        end
    end

    // =========================================================
    // soft restart watchdog
    // R9 fall back to hard restart after the wait
    always_ff @(posedge clk) begin
        if (rst || go_hard || go_util) begin
            wait_r   <= 1'b0;
            wait_s_r <= 9'h0;
        end else if (go_soft) begin
            // a new request beats a stale done report in the same cycle
            wait_r   <= 1'b1;
            wait_s_r <= 9'h0;
        end else if (hosted_os_restart_done) begin
            wait_r   <= 1'b0;
            wait_s_r <= 9'h0;
        end else if (wait_r && btn.sec_tick) begin
            wait_s_r <= wait_s_r + 9'h1;
            if (wait_s_r == 9'(SOFT_WAIT_S - 1)) begin
                wait_r <= 1'b0;
            end
        end
    end

    // =========================================================
    // request pulses
    // R2 R3 R4 R12 one-cycle requests; R10 R13 only a program-position ten-second hold reaches control, via controller_restart
    always_ff @(posedge clk) begin
        if (rst) begin
            soft_r <= 1'b0;
            hard_r <= 1'b0;
            util_r <= 1'b0;
            ctl_r  <= 1'b0;
        end else begin
            soft_r <= go_soft;
            hard_r <= go_hard || (wait_r && btn.sec_tick &&
                      wait_s_r == 9'(SOFT_WAIT_S - 1) && !hosted_os_restart_done);
            util_r <= go_util;
            ctl_r  <= go_util;
        end
    end

    // R11 start gate on firmware revision
    always_ff @(posedge clk) begin
        if (rst) begin
            run_en_r <= 1'b0;
        end else begin
            run_en_r <= firmware_rev >= `RBHD_WORK_REV;
        end
    end

    assign hosted_os_soft_restart = soft_r;
    assign hosted_os_hard_restart = hard_r;
    assign hosted_os_utilities    = util_r;
    assign controller_restart     = ctl_r;
    assign hosted_os_run_enable   = run_en_r;
    assign display_word           = disp_r;

    // =========================================================
    // checks
    soft_req_a: assert property (@(posedge clk) disable iff (rst) // R2
        go_soft |=> hosted_os_soft_restart && !hosted_os_hard_restart)
        else $error("soft request missing");
    hard_req_a: assert property (@(posedge clk) disable iff (rst) // R3
        go_hard |=> hosted_os_hard_restart)
        else $error("hard request missing");
    util_req_a: assert property (@(posedge clk) disable iff (rst) // R4
        hosted_os_utilities |-> controller_restart && $past(mode_switch) == RBHD_SW_PROGRAM)
        else $error("utilities without program position");
    mode_only_a: assert property (@(posedge clk) disable iff (rst) // R5
        act && iv == RBHD_IV_TEN && mode_switch != RBHD_SW_PROGRAM
        |=> !hosted_os_utilities && !hosted_os_soft_restart && !hosted_os_hard_restart)
        else $error("mode hold caused action");
    cancel_hold_a: assert property (@(posedge clk) disable iff (rst) // R6
        btn.held && iv == RBHD_IV_CANCEL |=> $stable(display_word))
        else $error("cancel changed display");
    hard_word_a: assert property (@(posedge clk) disable iff (rst) // R7
        btn.held && power_good && iv == RBHD_IV_HARD |=> display_word == `RBHD_WORD_HRDR)
        else $error("hard word not shown");
    no_power_a: assert property (@(posedge clk) disable iff (rst) // R1
        btn.release_p && !power_good |=> !hosted_os_soft_restart && !hosted_os_hard_restart)
        else $error("action without power");
    rev_gate_a: assert property (@(posedge clk) disable iff (rst) // R11
        firmware_rev < `RBHD_WORK_REV |=> !hosted_os_run_enable)
        else $error("start allowed at old revision");
    release_only_a: assert property (@(posedge clk) disable iff (rst) // R8
        hosted_os_soft_restart |-> $past(btn.release_p))
        else $error("soft request not at release");
endmodule // rbhd_top

// ---- rbhd_params.svh ----
// constants for the reset button hold decoder
`ifndef RBHD_PARAMS_SVH
`define RBHD_PARAMS_SVH
`define RBHD_CLK_HZ          50000000
`define RBHD_DEBOUNCE_MS     10
`define RBHD_DEBOUNCE_CYC    ((`RBHD_CLK_HZ / 1000) * `RBHD_DEBOUNCE_MS)
`define RBHD_SEC_CYC         `RBHD_CLK_HZ
`define RBHD_SOFT_MIN_S      1
`define RBHD_HARD_MIN_S      5
`define RBHD_UTIL_MIN_S      10
`define RBHD_CANCEL_S        15
`define RBHD_SOFT_WAIT_MIN   5
`define RBHD_SOFT_WAIT_S     (`RBHD_SOFT_WAIT_MIN * 60)
`define RBHD_WORK_REV        16'h3200
`define RBHD_HOLD_PULSE_CYC  2
// display words, four ascii characters
`define RBHD_WORD_BLANK      32'h20202020
`define RBHD_WORD_HRDR       32'h48524452
`define RBHD_WORD_UTIL       32'h5554494c
`define RBHD_WORD_MODE       32'h4d4f4445
`endif

// ---- rbhd_pkg.sv ----
// types for the reset button hold decoder
package rbhd_pkg;
    // switch positions
    typedef enum logic [1:0] {
        RBHD_SW_RUN,
        RBHD_SW_REMOTE,
        RBHD_SW_PROGRAM
    } rbhd_switch_type;
    // decoded hold interval
    typedef enum logic [2:0] {
        RBHD_IV_SHORT,
        RBHD_IV_SOFT,
        RBHD_IV_HARD,
        RBHD_IV_TEN,
        RBHD_IV_CANCEL
    } rbhd_interval_type;
endpackage

// ---- rbhd_btn_if.sv ----
// debounced button and seconds tick between the decoder modules
`timescale 1ns/100ps
interface rbhd_btn_if;
    logic       held;
    logic       press;
    logic       release_p;
    logic       sec_tick;
    modport src (output held, output press, output release_p, output sec_tick);
    modport dst (input held, input press, input release_p, input sec_tick);
endinterface

// ---- rbhd_debounce.sv ----
// button synchroniser, debouncer and seconds divider
`timescale 1ns/100ps
`include "rbhd_params.svh"
module rbhd_debounce #(
    // real rates by default; a bench may shorten them to reach whole seconds
    parameter int DEBOUNCE_CYC = `RBHD_DEBOUNCE_CYC,
    parameter int SEC_CYC      = `RBHD_SEC_CYC
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // raw pin, active low
    input  wire logic button_n,
    // debounced events
    rbhd_btn_if.src   btn
);
    logic        sync1_r;
    logic        sync2_r;
    logic        state_r;
    logic [19:0] db_cnt_r;
    logic [25:0] sec_cnt_r;

    // R14 input synchroniser
    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_r <= 1'b1;
            sync2_r <= 1'b1;
        end else begin
            sync1_r <= button_n;
            sync2_r <= sync1_r;
        end
    end

    // R14 debounce filter; level must hold before it is accepted
    always_ff @(posedge clk) begin
        if (rst) begin
            state_r  <= 1'b0;
            db_cnt_r <= 20'h0;
        end else if ((~sync2_r) == state_r) begin
            db_cnt_r <= 20'h0;
        end else if (db_cnt_r == 20'(DEBOUNCE_CYC - 1)) begin
            state_r  <= ~sync2_r;
            db_cnt_r <= 20'h0;
        end else begin
            db_cnt_r <= db_cnt_r + 20'h1;
        end
    end

    // R14 seconds divider, restarted at each press so holds are exact
    always_ff @(posedge clk) begin
        if (rst || btn.press || sec_cnt_r == 26'(SEC_CYC - 1)) begin
            sec_cnt_r <= 26'h0;
        end else begin
            sec_cnt_r <= sec_cnt_r + 26'h1;
        end
    end

    // edge strobes from the filtered level
    assign btn.held      = state_r;
    assign btn.press     = (~sync2_r) && !state_r && db_cnt_r == 20'(DEBOUNCE_CYC - 1);
    assign btn.release_p = sync2_r && state_r && db_cnt_r == 20'(DEBOUNCE_CYC - 1);
    assign btn.sec_tick  = sec_cnt_r == 26'(SEC_CYC - 1);
endmodule // rbhd_debounce

// ---- rbhd_partner.sv ----
// operator and hosted os model facing the reset button hold decoder
`timescale 1ns/100ps
module rbhd_partner #(
    parameter int DONE_DELAY = 16
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // operator request from the bench
    input  wire logic        hold_req,
    // requests from the decoder
    input  wire logic        soft_req,
    input  wire logic        hard_req,
    input  wire logic        util_req,
    input  wire logic        ctrl_req,
    // hosted os never reports back while high
    input  wire logic        silent,
    // pins toward the decoder
    output logic             button_n,
    output logic             restart_done,
    // activity seen
    output logic [15:0]      req_count
);
    logic [15:0] wait_r;
    logic        busy_r;

    // =====================================================
    // operator
    // operator picks the action by when the button is let go
    // contact opens to the pull-up level whenever nobody presses
    assign button_n = ~hold_req;

    // =====================================================
    // hosted os
    // restart finishes a short while after any request, never at once
    // a silent model plays an os that hangs and never comes back
    always @(posedge clk) begin
        if (rst) begin
            busy_r       <= 1'b0;
            wait_r       <= '0;
            req_count    <= '0;
            restart_done <= 1'b0;
        end else if (soft_req | hard_req | util_req | ctrl_req) begin
            req_count    <= req_count + 16'h0001;
            busy_r       <= 1'b1;
            wait_r       <= '0;
            restart_done <= 1'b0;
        end else begin
            restart_done <= busy_r && !silent && wait_r == 16'(DONE_DELAY);
            if (busy_r) begin
                wait_r <= wait_r + 16'h0001;
            end
            if (busy_r && wait_r == 16'(DONE_DELAY)) begin
                busy_r <= 1'b0;
            end
        end
    end
endmodule // rbhd_partner

// ---- rbhd_tb_top.sv ----
// self-checking bench for the reset button hold decoder
`timescale 1ns/100ps
`include "rbhd_params.svh"
module rbhd_tb_top;
    import rbhd_pkg::*;
    logic            clk;
    logic            rst;
    logic            power_good;
    rbhd_switch_type mode_switch;
    logic [15:0]     firmware_rev;
    logic            button_n;
    logic            restart_done;
    logic            hold_req;
    logic            run_en;
    logic            soft_p;
    logic            hard_p;
    logic            util_p;
    logic            ctrl_p;
    logic [31:0]     word;
    logic [15:0]     req_count;
    int              num_errors;
    int              tests_run;
    int              cycles;
    logic            os_silent;
    int              soft_n;
    int              hard_n;
    int              util_n;
    int              ctrl_n;
    // short rates so whole seconds fit the run: 8-cycle filter, 32-cycle second
    localparam int DB_CYC = 8;
    localparam int SEC    = 32;

    // =====================================================
    // clock, stimulus defaults, watchdog
    initial clk = 1'b0;
    always #10 clk = ~clk;
    initial begin
        rst = 1'b1;
        power_good = 1'b1;
        mode_switch = RBHD_SW_RUN;
        firmware_rev = 16'h0100;
        hold_req = 1'b0;
        num_errors = 0;
        tests_run = 0;
        cycles = 0;
        os_silent = 1'b0;
        soft_n = 0;
        hard_n = 0;
        util_n = 0;
        ctrl_n = 0;
    end
    // the whole run needs well under this many cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            num_errors++;
            print_verdict();
        end
    end

    // =====================================================
    // design and far side
    rbhd_top #(.DEBOUNCE_CYC(DB_CYC), .SEC_CYC(SEC)) u_rbhd_top (
        .clk(clk), .rst(rst), .power_good(power_good), .mode_switch(mode_switch),
        .firmware_rev(firmware_rev), .button_n(button_n),
        .hosted_os_restart_done(restart_done), .hosted_os_run_enable(run_en),
        .hosted_os_soft_restart(soft_p), .hosted_os_hard_restart(hard_p),
        .hosted_os_utilities(util_p), .controller_restart(ctrl_p), .display_word(word)
    );
    rbhd_partner u_rbhd_partner (
        .clk(clk), .rst(rst), .hold_req(hold_req), .soft_req(soft_p), .hard_req(hard_p),
        .util_req(util_p), .ctrl_req(ctrl_p), .button_n(button_n),
        .restart_done(restart_done), .req_count(req_count), .silent(os_silent)
    );
    // request pulses counted mid-cycle, while each one stands
    always @(negedge clk) begin
        if (soft_p === 1'b1) soft_n++;
        if (hard_p === 1'b1) hard_n++;
        if (util_p === 1'b1) util_n++;
        if (ctrl_p === 1'b1) ctrl_n++;
    end

    // =====================================================
    // helpers
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // operator presses and keeps holding for n cycles
    task automatic hold_button(input int n);
        hold_req = 1'b1;
        step(n);
    endtask
    // operator lets go; long enough for filter and request pulse
    task automatic let_go();
        hold_req = 1'b0;
        step(40);
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // =====================================================
    // scenarios
    // outputs quiet while reset is held
    task automatic test_reset();
        step(6);
        check("soft pulse", 32'h0, {31'h0, soft_p});
        check("hard pulse", 32'h0, {31'h0, hard_p});
        check("util pulse", 32'h0, {31'h0, util_p});
        check("ctrl pulse", 32'h0, {31'h0, ctrl_p});
        check("run enable", 32'h0, {31'h0, run_en});
        check("display", `RBHD_WORD_BLANK, word);
        rst = 1'b0;
        step(1);
        $display("test reset done");
    endtask
    // revisions either side of the working one
    task automatic test_revision();
        logic [15:0] revs [6];
        logic        exp_en [6];
        revs = '{16'h0100, 16'h31ff, 16'h3200, 16'h3201, 16'hffff, 16'h0000};
        exp_en = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
        for (int i = 0; i < 6; i++) begin
            firmware_rev = revs[i];
            step(2);
            check("run enable", {31'h0, exp_en[i]}, {31'h0, run_en});
        end
        firmware_rev = 16'h3200;
        $display("test revision done");
    endtask
    // bouncing, short presses powered and hard-length presses unpowered, every position
    task automatic test_short_press();
        for (int p = 0; p < 2; p++) begin
            for (int s = 0; s < 3; s++) begin
                power_good = (p == 0);
                mode_switch = rbhd_switch_type'(s);
                // bounce shorter than the filter never counts
                for (int b = 0; b < 8; b++) begin
                    hold_req = ~hold_req;
                    step(DB_CYC - 5);
                end
                // under a second powered, a hard-length hold unpowered
                hold_button((p == 0) ? SEC / 2 : 6 * SEC + SEC / 4);
                let_go();
                check("requests", 32'h0, {16'h0, req_count});
                check("display", `RBHD_WORD_BLANK, word);
                check("run enable", 32'h1, {31'h0, run_en});
            end
        end
        power_good = 1'b1;
        check("requests", 32'h0, {16'h0, req_count});
        $display("test short press done");
    endtask
    // one to five seconds: soft restart, answered, so no fallback follows
    task automatic test_soft();
        mode_switch = RBHD_SW_RUN;
        hold_button(2 * SEC + SEC / 2);
        let_go();
        check("soft pulses", 32'd1, soft_n);
        check("hard pulses", 32'd0, hard_n);
        check("ctrl pulses", 32'd0, ctrl_n);
        step(`RBHD_SOFT_WAIT_S * SEC + 4 * SEC);
        check("hard pulses", 32'd0, hard_n);
        $display("test soft done");
    endtask
    // five to ten seconds: hard word while held, hard restart at release
    task automatic test_hard();
        mode_switch = RBHD_SW_REMOTE;
        hold_button(6 * SEC + SEC / 2);
        check("display", `RBHD_WORD_HRDR, word);
        let_go();
        check("hard pulses", 32'd1, hard_n);
        check("soft pulses", 32'd1, soft_n);
        check("requests", 32'd2, {16'h0, req_count});
        $display("test hard done");
    endtask
    // ten to fifteen seconds in every switch position
    task automatic test_ten();
        for (int s = 0; s < 3; s++) begin
            mode_switch = rbhd_switch_type'(s);
            hold_button(11 * SEC + SEC / 2);
            check("display", (s == 2) ? `RBHD_WORD_UTIL : `RBHD_WORD_MODE, word);
            let_go();
            check("util pulses", (s == 2) ? 32'd1 : 32'd0, util_n);
            check("ctrl pulses", (s == 2) ? 32'd1 : 32'd0, ctrl_n);
            check("hard pulses", 32'd1, hard_n);
        end
        check("run enable", 32'h1, {31'h0, run_en});
        $display("test ten done");
    endtask
    // fifteen seconds or more: nothing happens and the word stays
    task automatic test_cancel();
        mode_switch = RBHD_SW_PROGRAM;
        hold_button(16 * SEC + SEC / 2);
        check("display", `RBHD_WORD_UTIL, word);
        let_go();
        check("display", `RBHD_WORD_UTIL, word);
        check("util pulses", 32'd1, util_n);
        check("requests", 32'd3, {16'h0, req_count});
        $display("test cancel done");
    endtask
    // a soft restart never answered falls back to a hard restart
    task automatic test_watchdog();
        os_silent = 1'b1;
        mode_switch = RBHD_SW_RUN;
        hold_button(2 * SEC + SEC / 2);
        let_go();
        check("soft pulses", 32'd2, soft_n);
        step(`RBHD_SOFT_WAIT_S * SEC - 4 * SEC);
        check("hard pulses", 32'd1, hard_n);
        step(8 * SEC);
        check("hard pulses", 32'd2, hard_n);
        os_silent = 1'b0;
        $display("test watchdog done");
    endtask

    // =====================================================
    // main sequence
    initial begin
        step(0);
        test_reset();
        test_revision();
        test_short_press();
        test_soft();
        test_hard();
        test_ten();
        test_cancel();
        test_watchdog();
        print_verdict();
    end
endmodule // rbhd_tb_top
